// [rtl/cpuor_defs.svh]
`ifndef CPUOR_DEFS_SVH
`define CPUOR_DEFS_SVH

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CPUOR_ACC_RST 8'h00
`define CPUOR_PC_RST 13'h0000
`define CPUOR_MIE_RST 1'b0
`define CPUOR_Z_RST 1'b0

// ------------------------------------------------------------
// Operation codes on op_in
// ------------------------------------------------------------
`define CPUOR_OP_IDLE 4'h0
`define CPUOR_OP_OR_MEM 4'h1
`define CPUOR_OP_OR_IMM 4'h2
`define CPUOR_OP_OR_INTO 4'h3
`define CPUOR_OP_SUB_EXIT 4'h4
`define CPUOR_OP_RET_VAL 4'h5
`define CPUOR_OP_INT_EXIT 4'h6
`define CPUOR_OP_ROT_LEFT 4'h7

`endif

// [rtl/cpuor_exec.sv]
// Behaviour
// - Idle op changes nothing, advances
// - OR memory into work register, zero
// - OR immediate into work register, zero
// - OR work register into memory, zero
// - Subroutine exit pops stack into counter
// - Return pops stack, loads immediate
// - Interrupt exit pops, sets master enable
// - Pending interrupt serviced before main resumes
// - Rotate memory left, bit7 to bit0
`timescale 1ns/1ns
`include "cpuor_defs.svh"

module cpuor_exec
    import cpuor_pkg::*;
#(
    parameter int PC_W = 13
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic op_valid_in,
    input wire logic [3:0] op_in,
    input wire logic [7:0] imm_in,
    input wire logic [7:0] mem_rdata_in,
    input wire logic [PC_W-1:0] stack_top_in,
    input wire logic irq_pending_in,
    output logic [7:0] acc_out,
    output logic zero_out,
    output logic master_irq_enable_out,
    output logic [PC_W-1:0] pc_out,
    output logic stack_pop_out,
    output logic mem_we_out,
    output logic [7:0] mem_wdata_out,
    output logic irq_take_out
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    cpuor_op_t op;
    logic is_or_into;
    logic is_sub_exit;
    logic is_ret_val;
    logic is_int_exit;
    logic is_rot_left;
    logic is_ret;
    logic is_mem_write;

    assign op = cpuor_op_t'(op_in);

    // Codes 8 to 15 match no item below and so run as idle
    assign is_or_into = op_valid_in && (op == CPUOR_OR_INTO);
    assign is_sub_exit = op_valid_in && (op == CPUOR_SUB_EXIT);
    assign is_ret_val = op_valid_in && (op == CPUOR_RET_VAL);
    assign is_int_exit = op_valid_in && (op == CPUOR_INT_EXIT);
    assign is_rot_left = op_valid_in && (op == CPUOR_ROT_LEFT);
    assign is_ret = is_sub_exit || is_ret_val || is_int_exit;
    assign is_mem_write = is_or_into || is_rot_left;

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    logic [7:0] or_mem;
    logic [7:0] or_imm;
    logic [7:0] rot;
    logic [PC_W-1:0] pc_step;

    assign or_mem = acc_out | mem_rdata_in;
    assign or_imm = acc_out | imm_in;
    // Plain rotate, no carry takes part
    assign rot = {mem_rdata_in[6:0], mem_rdata_in[7]};
    // Wraps at the top of program space, as the counter width allows
    assign pc_step = pc_out + PC_W'(1);

    // Pop is a strobe for the external stack, same cycle as the op
    assign stack_pop_out = is_ret;

    // ------------------------------------------------------------
    // Work register
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            acc_out <= `CPUOR_ACC_RST;
        end else if (op_valid_in) begin
            case (op)
                CPUOR_OR_MEM: begin
                    acc_out <= or_mem;
                end
                CPUOR_OR_IMM: begin
                    acc_out <= or_imm;
                end
                CPUOR_RET_VAL: begin
                    acc_out <= imm_in;
                end
                // Or-into-memory, rotate and plain returns leave it alone
                default: begin
                    acc_out <= acc_out;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Zero flag
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            zero_out <= `CPUOR_Z_RST;
        end else if (op_valid_in) begin
            case (op)
                CPUOR_OR_MEM: begin
                    zero_out <= (or_mem == 8'h00);
                end
                CPUOR_OR_IMM: begin
                    zero_out <= (or_imm == 8'h00);
                end
                CPUOR_OR_INTO: begin
                    zero_out <= (or_mem == 8'h00);
                end
                // Rotate and returns leave flags alone
                default: begin
                    zero_out <= zero_out;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Memory write-back
    // ------------------------------------------------------------
    // Pulse lasts one cycle; the write port needs no more
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            mem_we_out <= 1'b0;
        end else begin
            mem_we_out <= is_mem_write;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            mem_wdata_out <= 8'h00;
        end else if (op_valid_in) begin
            case (op)
                CPUOR_OR_INTO: begin
                    mem_wdata_out <= or_mem;
                end
                CPUOR_ROT_LEFT: begin
                    mem_wdata_out <= rot;
                end
                // Other ops keep the last byte; the strobe is low for them
                default: begin
                    mem_wdata_out <= mem_wdata_out;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Master enable
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            master_irq_enable_out <= `CPUOR_MIE_RST;
        end else if (op_valid_in) begin
            case (op)
                CPUOR_INT_EXIT: begin
                    master_irq_enable_out <= 1'b1;
                end
                // No op here clears it, only srst_in does; the rest is left to outside logic
                default: begin
                    master_irq_enable_out <= master_irq_enable_out;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pending service
    // ------------------------------------------------------------
    // Flagging service here stops the core fetching main-line code first
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            irq_take_out <= 1'b0;
        end else if (is_int_exit && irq_pending_in) begin
            irq_take_out <= 1'b1;
        end else begin
            irq_take_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pc_out <= PC_W'(`CPUOR_PC_RST);
        end else if (op_valid_in) begin
            case (op)
                CPUOR_SUB_EXIT: begin
                    pc_out <= stack_top_in;
                end
                CPUOR_RET_VAL: begin
                    pc_out <= stack_top_in;
                end
                CPUOR_INT_EXIT: begin
                    pc_out <= stack_top_in;
                end
                // Idle, the ORs, the rotate and unused codes step on
                default: begin
                    pc_out <= pc_step;
                end
            endcase
        end
    end

endmodule // cpuor_exec

// [rtl/cpuor_pkg.sv]
package cpuor_pkg;
    typedef enum logic [3:0] {
        CPUOR_IDLE = 4'h0,
        CPUOR_OR_MEM = 4'h1,
        CPUOR_OR_IMM = 4'h2,
        CPUOR_OR_INTO = 4'h3,
        CPUOR_SUB_EXIT = 4'h4,
        CPUOR_RET_VAL = 4'h5,
        CPUOR_INT_EXIT = 4'h6,
        CPUOR_ROT_LEFT = 4'h7
    } cpuor_op_t;
endpackage

// [test/cpuor_exec_assertions.sv]
`timescale 1ns/1ns
module cpuor_exec_assertions
    import cpuor_pkg::*;
#(parameter int PC_W = 13) (
    input wire logic clock_in, srst_in, op_valid_in, irq_pending_in,
    input wire logic [3:0] op_in,
    input wire logic [7:0] imm_in, mem_rdata_in,
    input wire logic [PC_W-1:0] stack_top_in, pc_out,
    input wire logic [7:0] acc_out, mem_wdata_out,
    input wire logic zero_out, master_irq_enable_out, stack_pop_out, mem_we_out, irq_take_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    sequence s_or_mem; op_valid_in && op_in == 4'h1; endsequence
    sequence s_or_imm; op_valid_in && op_in == 4'h2; endsequence
    sequence s_into; op_valid_in && op_in == 4'h3; endsequence
    sequence s_rot; op_valid_in && op_in == 4'h7; endsequence
    sequence s_ret; op_valid_in && op_in inside {4'h4, 4'h5, 4'h6}; endsequence
    sequence s_ret_val; op_valid_in && op_in == 4'h5; endsequence
    sequence s_int_exit; op_valid_in && op_in == 4'h6; endsequence
    sequence s_idle; op_valid_in && (op_in == 4'h0 || op_in[3]); endsequence
    chk_or_mem: assert property (
        s_or_mem |=> acc_out == ($past(acc_out) | $past(mem_rdata_in)) && zero_out == (acc_out == 8'h00)
    ) else $error("or from memory wrong");
    chk_or_imm: assert property (
        s_or_imm |=> acc_out == ($past(acc_out) | $past(imm_in)) && zero_out == (acc_out == 8'h00)
    ) else $error("or immediate wrong");
    chk_or_into: assert property (
        s_into |=> mem_we_out && $stable(acc_out) && mem_wdata_out == ($past(acc_out) | $past(mem_rdata_in))
        && zero_out == (mem_wdata_out == 8'h00)
    ) else $error("or into memory wrong");
    chk_rot_left: assert property (
        s_rot |=> mem_we_out && $stable(zero_out) && $stable(acc_out)
        && mem_wdata_out == {$past(mem_rdata_in[6:0]), $past(mem_rdata_in[7])}
    ) else $error("rotate wrong");
    chk_ret_pop: assert property (
        s_ret |-> stack_pop_out ##1 pc_out == $past(stack_top_in) && $stable(zero_out)
    ) else $error("return pop wrong");
    chk_ret_value: assert property (
        s_ret_val |=> acc_out == $past(imm_in) && $stable(zero_out)
    ) else $error("return value wrong");
    chk_int_exit: assert property (
        s_int_exit |=> master_irq_enable_out && irq_take_out == $past(irq_pending_in)
    ) else $error("interrupt exit wrong");
    chk_idle_hold: assert property (
        s_idle |=> pc_out == $past(pc_out) + 1'b1 && $stable(acc_out) && $stable(zero_out) && !mem_we_out
    ) else $error("idle op changed state");
    chk_quiet_hold: assert property (
        !op_valid_in |=> $stable(acc_out) && $stable(zero_out) && $stable(pc_out) && !mem_we_out && !irq_take_out
    ) else $error("state changed with no op");
    chk_pop_only: assert property (
        stack_pop_out |-> op_valid_in && op_in inside {4'h4, 4'h5, 4'h6}
    ) else $error("stack pop without return");
    chk_enable_hold: assert property (
        !(op_valid_in && op_in == 4'h6) |=> $stable(master_irq_enable_out)
    ) else $error("master enable changed");
endmodule // cpuor_exec_assertions
bind cpuor_exec cpuor_exec_assertions #(.PC_W(PC_W)) chk_inst (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .op_valid_in(op_valid_in),
    .irq_pending_in(irq_pending_in),
    .op_in(op_in),
    .imm_in(imm_in),
    .mem_rdata_in(mem_rdata_in),
    .stack_top_in(stack_top_in),
    .pc_out(pc_out),
    .acc_out(acc_out),
    .mem_wdata_out(mem_wdata_out),
    .zero_out(zero_out),
    .master_irq_enable_out(master_irq_enable_out),
    .stack_pop_out(stack_pop_out),
    .mem_we_out(mem_we_out),
    .irq_take_out(irq_take_out)
);

// [test/cpuor_exec_tb.sv]
`timescale 1ns/1ns
module cpuor_exec_tb;
    logic clock_in = 0, srst_in = 1, op_valid_in = 0, irq_pending_in = 0;
    logic [3:0] op_in = 0;
    logic [7:0] imm_in = 0, mem_rdata_in = 0, acc_out, mem_wdata_out;
    logic [12:0] stack_top_in = 13'h1abc, pc_out, pc_old;
    logic zero_out, master_irq_enable_out, stack_pop_out, mem_we_out, irq_take_out;
    int mismatches = 0, checks = 0;
    always #20 clock_in = ~clock_in;
    cpuor_exec cpuor_exec_inst (.*);
    task chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Memory byte and immediate share one value to keep scenarios short
    task op(input logic [3:0] c, input logic [7:0] d);
        @(negedge clock_in);
        {op_valid_in, op_in, imm_in, mem_rdata_in} = {1'b1, c, d, d};
        @(negedge clock_in);
        op_valid_in = 0;
    endtask
    task t_or;
        op(4'h2, 8'h00); chk(zero_out, 1);
        op(4'h1, 8'h5a); chk({zero_out, acc_out}, 16'h5a);
        op(4'h3, 8'ha5); chk({mem_we_out, mem_wdata_out, acc_out, zero_out}, 18'h3feb4);
    endtask
    task t_rot;
        op(4'h7, 8'h81); chk({mem_we_out, mem_wdata_out, zero_out}, 10'h206);
    endtask
    task t_ret;
        @(negedge clock_in);
        {op_valid_in, op_in} = {1'b1, 4'h4};
        #1 chk(stack_pop_out, 1);
        @(negedge clock_in);
        op_valid_in = 0;
        chk(pc_out, 13'h1abc);
        #1 chk(stack_pop_out, 0);
        op(4'h5, 8'h00); chk({zero_out, acc_out}, 16'h0);
        irq_pending_in = 1;
        op(4'h6, 8'h00); chk({master_irq_enable_out, irq_take_out}, 2'h3);
    endtask
    task t_idle;
        pc_old = pc_out;
        op(4'h0, 8'hff); chk({acc_out, pc_out}, {8'h00, pc_old + 13'h1});
        pc_old = pc_out;
        op(4'h9, 8'h77); chk({mem_we_out, acc_out, pc_out}, {1'b0, 8'h00, pc_old + 13'h1});
    endtask
    task t_reset;
        @(negedge clock_in);
        srst_in = 1;
        @(negedge clock_in);
        chk({acc_out, zero_out, master_irq_enable_out, pc_out}, 23'h0);
        chk({mem_we_out, mem_wdata_out, irq_take_out, stack_pop_out}, 11'h0);
        srst_in = 0;
        op(4'h2, 8'h3c); chk({zero_out, acc_out}, 16'h3c);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clock_in);
        srst_in = 0;
        t_or; t_rot; t_ret; t_idle; t_reset; wrap_up;
    end
    initial begin
        #20000 mismatches++;
        wrap_up;
    end
endmodule // cpuor_exec_tb
